/* hw/p1g_pkg.sv */
// shared constants and types for the port 1 pin function block
package p1g_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] P1G_OFS_FUNC_SEL = 5'h00;
    localparam logic [4:0] P1G_OFS_DIR = 5'h04;
    localparam logic [4:0] P1G_OFS_OUT_VAL = 5'h08;
    localparam logic [4:0] P1G_OFS_PULLUP = 5'h0c;
    localparam logic [4:0] P1G_OFS_PORT2 = 5'h10;
    localparam logic [4:0] P1G_OFS_PIN_LEVEL = 5'h14;

    // function select fields
    localparam int P1G_FS_EXT_INT_THREE_SELECT = 7;
    localparam int P1G_FS_EXT_INT_TWO_SELECT = 6;
    localparam int P1G_FS_EXT_INT_ONE_SELECT = 5;
    localparam int P1G_FS_EXT_INT_ZERO_SELECT = 4;
    localparam int P1G_FS_TXD_SELECT = 1;
    localparam int P1G_FS_TIMER_CLOCK_OUT_SELECT = 0;
    localparam logic [7:0] P1G_FS_WRITABLE = 8'hf3;
    localparam logic [7:0] P1G_FS_READ_ONES = 8'h0c;

    // port 1 has no pin 3
    localparam int P1G_ABSENT_PIN = 3;
    localparam logic [7:0] P1G_PIN_IMPL = 8'hf7;
    localparam logic [7:0] P1G_DATA_READ_ONES = 8'h08;

    // port 2 pin 2 control fields
    localparam int P1G_P2_DIR_BIT = 0;
    localparam int P1G_P2_DATA_BIT = 1;
    localparam logic [7:0] P1G_P2_WRITABLE = 8'h03;

    // reset values
    localparam logic [7:0] P1G_RST_FUNC_SEL = 8'h00;
    localparam logic [7:0] P1G_RST_DIR = 8'h00;
    localparam logic [7:0] P1G_RST_OUT_VAL = 8'h00;
    localparam logic [7:0] P1G_RST_PULLUP = 8'h00;
    localparam logic [7:0] P1G_RST_PORT2 = 8'h00;
    localparam logic [31:0] P1G_UNMAPPED_READ = 32'h0000_0000;
    localparam logic [3:0] P1G_EXT_INT_IDLE = 4'hf;

    // the bus access now on the slave inputs, handed unqualified from the slave to the register file and read path
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
        logic lane0;
    } p1g_bus_req_t;

    // per-pin drive result
    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
    } p1g_pin_drive_t;
endpackage

/* hw/p1g_avs.sv */
// avalon-mm slave handshake: one wait cycle, then one acknowledge cycle
`timescale 1ns/1ps
module p1g_avs import p1g_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic avs_waitrequest,
    output logic ack_cycle,
    output p1g_bus_req_t req
);
    logic wait_req;
    logic next_wait_req;

    // low for exactly one cycle per request, so each request commits once
    always_comb begin
        next_wait_req = 1'b1;
        if ((avs_read || avs_write) && wait_req) begin
            next_wait_req = 1'b0;
        end
    end

    // waitrequest leaves straight from this flop
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wait_req <= 1'b1;
        end else begin
            wait_req <= next_wait_req;
        end
    end

    always_comb begin
        avs_waitrequest = wait_req;
        ack_cycle = !wait_req && (avs_read || avs_write);
        req.wr = avs_write;
        req.rd = avs_read;
        req.addr = avs_address;
        req.wdata = avs_writedata[7:0];
        req.lane0 = avs_byteenable[0];
    end
endmodule

/* hw/p1g_pin_cell.sv */
// one pin: general i/o or alternate function, with pull-up gating
`timescale 1ns/1ps
module p1g_pin_cell import p1g_pkg::*; #(
    parameter bit ALT_IS_OUTPUT = 1'b0
) (
    input wire logic alt_sel,
    input wire logic dir,
    input wire logic data,
    input wire logic pullup_en,
    input wire logic alt_out,
    output p1g_pin_drive_t drive
);
    always_comb begin
        drive.out = 1'b0;
        drive.oe = 1'b0;
        if (alt_sel) begin
            // direction bit is ignored here
            drive.oe = ALT_IS_OUTPUT;
            drive.out = ALT_IS_OUTPUT ? alt_out : 1'b0;
        end else begin
            drive.oe = dir;
            drive.out = dir ? data : 1'b0;
        end
        // pull-up only on an undriven input
        drive.pu = pullup_en && !dir && !drive.oe;
    end
endmodule

/* hw/p1g_port.sv */
// port 1 pin function and direction block with avalon-mm registers
`timescale 1ns/1ps
module p1g_port import p1g_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port1_pin_in,
    output logic [7:0] port1_pin_out,
    output logic [7:0] port1_pin_oe,
    output logic [7:0] port1_pullup_on,
    input wire logic port_two_pin_two_in,
    output logic port_two_pin_two_out,
    output logic port_two_pin_two_oe,
    input wire logic serial_txd,
    input wire logic timer_clock,
    output logic [3:0] ext_int_n,
    output logic timer_v_trigger_in
);
    p1g_bus_req_t req;
    logic ack_cycle;

    logic [7:0] pin_function_select;
    logic [7:0] pin_direction_control;
    logic [7:0] port_output_value;
    logic [7:0] port_pullup_enable;
    logic [7:0] port2_ctrl;
    logic [7:0] next_pin_function_select;
    logic [7:0] next_pin_direction_control;
    logic [7:0] next_port_output_value;
    logic [7:0] next_port_pullup_enable;
    logic [7:0] next_port2_ctrl;

    logic [31:0] next_avs_readdata;
    logic [7:0] next_port1_pin_out;
    logic [7:0] next_port1_pin_oe;
    logic [7:0] next_port1_pullup_on;
    logic next_port_two_pin_two_out;
    logic next_port_two_pin_two_oe;
    logic [3:0] next_ext_int_n;
    logic next_timer_v_trigger_in;

    p1g_pin_drive_t drive [7:0];
    p1g_pin_drive_t p2_drive;
    logic [7:0] alt_sel;
    logic [7:0] alt_out;

    // write of one byte lane, masked to the bits that exist
    function automatic logic [7:0] p1g_masked(
        input logic [7:0] old,
        input logic [7:0] wdata,
        input logic [7:0] mask
    );
        p1g_masked = (old & ~mask) | (wdata & mask);
    endfunction

    // read view: stored value for outputs, pin level for inputs
    function automatic logic [7:0] p1g_data_view(
        input logic [7:0] stored,
        input logic [7:0] pins,
        input logic [7:0] dir
    );
        p1g_data_view = (stored & dir) | (pins & ~dir);
    endfunction

    p1g_avs u_avs (
        .mclk(mclk),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest),
        .ack_cycle(ack_cycle),
        .req(req)
    );

    // ---- register file ----
    always_comb begin
        next_pin_function_select = pin_function_select;
        next_pin_direction_control = pin_direction_control;
        next_port_output_value = port_output_value;
        next_port_pullup_enable = port_pullup_enable;
        next_port2_ctrl = port2_ctrl;
        // a write only counts on the acknowledge edge and with lane 0 enabled
        if (ack_cycle && req.wr && req.lane0) begin
            case (req.addr)
                P1G_OFS_FUNC_SEL: begin
                    // reserved bits 3 and 2 hold no storage
                    next_pin_function_select =
                        p1g_masked(pin_function_select, req.wdata, P1G_FS_WRITABLE);
                end
                P1G_OFS_DIR: begin
                    // bit 3 has no flop behind it
                    next_pin_direction_control =
                        p1g_masked(pin_direction_control, req.wdata, P1G_PIN_IMPL);
                end
                P1G_OFS_OUT_VAL: begin
                    // output value kept apart from direction
                    next_port_output_value =
                        p1g_masked(port_output_value, req.wdata, P1G_PIN_IMPL);
                end
                P1G_OFS_PULLUP: begin
                    next_port_pullup_enable =
                        p1g_masked(port_pullup_enable, req.wdata, P1G_PIN_IMPL);
                end
                P1G_OFS_PORT2: begin
                    next_port2_ctrl = p1g_masked(port2_ctrl, req.wdata, P1G_P2_WRITABLE);
                end
                default: begin
                    // unmapped writes are dropped
                    next_port2_ctrl = port2_ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // every pin comes up as a general input
            pin_function_select <= P1G_RST_FUNC_SEL;
            pin_direction_control <= P1G_RST_DIR;
            port_output_value <= P1G_RST_OUT_VAL;
            port_pullup_enable <= P1G_RST_PULLUP;
            port2_ctrl <= P1G_RST_PORT2;
        end else begin
            pin_function_select <= next_pin_function_select;
            pin_direction_control <= next_pin_direction_control;
            port_output_value <= next_port_output_value;
            port_pullup_enable <= next_port_pullup_enable;
            port2_ctrl <= next_port2_ctrl;
        end
    end

    // ---- read path ----
    always_comb begin
        next_avs_readdata = avs_readdata;
        // load on the wait cycle so data stands at the acknowledge edge
        if (req.rd && avs_waitrequest) begin
            next_avs_readdata = P1G_UNMAPPED_READ;
            case (req.addr)
                P1G_OFS_FUNC_SEL: begin
                    next_avs_readdata[7:0] = pin_function_select | P1G_FS_READ_ONES;
                end
                P1G_OFS_DIR: begin
                    // write-only; software keeps its own shadow
                    next_avs_readdata[7:0] = 8'h00;
                end
                P1G_OFS_OUT_VAL: begin
                    next_avs_readdata[7:0] = p1g_data_view(port_output_value,
                        port1_pin_in, pin_direction_control) | P1G_DATA_READ_ONES;
                end
                P1G_OFS_PULLUP: begin
                    next_avs_readdata[7:0] = port_pullup_enable | P1G_DATA_READ_ONES;
                end
                P1G_OFS_PORT2: begin
                    next_avs_readdata[P1G_P2_DIR_BIT] = 1'b0;
                    next_avs_readdata[P1G_P2_DATA_BIT] = port2_ctrl[P1G_P2_DIR_BIT] ?
                        port2_ctrl[P1G_P2_DATA_BIT] : port_two_pin_two_in;
                end
                P1G_OFS_PIN_LEVEL: begin
                    // raw levels, handy while a pin serves its alternate function
                    next_avs_readdata[7:0] = (port1_pin_in & P1G_PIN_IMPL) | P1G_DATA_READ_ONES;
                end
                default: begin
                    next_avs_readdata = P1G_UNMAPPED_READ;
                end
            endcase
        end
    end

    // ---- pin functions ----
    always_comb begin
        alt_sel = 8'h00;
        alt_out = 8'h00;
        alt_sel[7] = pin_function_select[P1G_FS_EXT_INT_THREE_SELECT];
        alt_sel[6] = pin_function_select[P1G_FS_EXT_INT_TWO_SELECT];
        alt_sel[5] = pin_function_select[P1G_FS_EXT_INT_ONE_SELECT];
        alt_sel[4] = pin_function_select[P1G_FS_EXT_INT_ZERO_SELECT];
        alt_sel[0] = pin_function_select[P1G_FS_TIMER_CLOCK_OUT_SELECT];
        alt_out[0] = timer_clock;
    end

    for (genvar i = 0; i < 8; i++) begin : g_pin
        if (i == P1G_ABSENT_PIN) begin : g_absent
            // no pin here: never driven, never pulled
            assign drive[i] = '0;
        end else begin : g_cell
            p1g_pin_cell #(
                .ALT_IS_OUTPUT(i == 0)
            ) u_cell (
                .alt_sel(alt_sel[i]),
                .dir(pin_direction_control[i]),
                .data(port_output_value[i]),
                .pullup_en(port_pullup_enable[i]),
                .alt_out(alt_out[i]),
                .drive(drive[i])
            );
        end
    end

    // port 2 pin 2 has no pull-up control
    p1g_pin_cell #(
        .ALT_IS_OUTPUT(1'b1)
    ) u_p2_cell (
        .alt_sel(pin_function_select[P1G_FS_TXD_SELECT]),
        .dir(port2_ctrl[P1G_P2_DIR_BIT]),
        .data(port2_ctrl[P1G_P2_DATA_BIT]),
        .pullup_en(1'b0),
        .alt_out(serial_txd),
        .drive(p2_drive)
    );

    always_comb begin
        for (int k = 0; k < 8; k++) begin
            next_port1_pin_out[k] = drive[k].out;
            next_port1_pin_oe[k] = drive[k].oe;
            next_port1_pullup_on[k] = drive[k].pu;
        end
        next_port_two_pin_two_out = p2_drive.out;
        next_port_two_pin_two_oe = p2_drive.oe;
        // interrupt inputs are active low, idle high while not selected
        next_ext_int_n = P1G_EXT_INT_IDLE;
        for (int k = 0; k < 4; k++) begin
            if (alt_sel[k + 4]) begin
                next_ext_int_n[k] = port1_pin_in[k + 4];
            end
        end
        next_timer_v_trigger_in = alt_sel[7] ? port1_pin_in[7] : 1'b0;
    end

    // outputs registered: pin paths lag one clock behind register writes
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_readdata <= P1G_UNMAPPED_READ;
            port1_pin_out <= 8'h00;
            port1_pin_oe <= 8'h00;
            port1_pullup_on <= 8'h00;
            port_two_pin_two_out <= 1'b0;
            port_two_pin_two_oe <= 1'b0;
            ext_int_n <= P1G_EXT_INT_IDLE;
            timer_v_trigger_in <= 1'b0;
        end else begin
            avs_readdata <= next_avs_readdata;
            port1_pin_out <= next_port1_pin_out;
            port1_pin_oe <= next_port1_pin_oe;
            port1_pullup_on <= next_port1_pullup_on;
            port_two_pin_two_out <= next_port_two_pin_two_out;
            port_two_pin_two_oe <= next_port_two_pin_two_oe;
            ext_int_n <= next_ext_int_n;
            timer_v_trigger_in <= next_timer_v_trigger_in;
        end
    end
endmodule

/* testbench/p1g_port_properties.sv */
// concurrent checks on the port 1 pin block ports
`timescale 1ns/1ps
module p1g_port_properties import p1g_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] port1_pin_in,
    input wire logic [7:0] port1_pin_out,
    input wire logic [7:0] port1_pin_oe,
    input wire logic [7:0] port1_pullup_on,
    input wire logic [3:0] ext_int_n,
    input wire logic timer_v_trigger_in
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack_once;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_ack_one_cycle;
        s_req_seen |=> s_ack_once;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("answer not one cycle");
    property p_idle_wait;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
    property p_rd_upper_zero;
        avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper read bits set");
    property p_reset_state;
        $rose(reset_n) |-> avs_waitrequest && port1_pin_oe == 8'h00 && ext_int_n == 4'hf;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset");
    property p_no_pin3;
        !port1_pin_oe[3] && !port1_pullup_on[3];
    endproperty
    a_no_pin3: assert property (p_no_pin3) else $error("absent pin driven");
    property p_pullup_vs_oe;
        (port1_pullup_on & port1_pin_oe) == 8'h00;
    endproperty
    a_pullup_vs_oe: assert property (p_pullup_vs_oe) else $error("pull-up on output");
    property p_out_undriven;
        (port1_pin_out & ~port1_pin_oe) == 8'h00;
    endproperty
    a_out_undriven: assert property (p_out_undriven) else $error("value on undriven pin");
    property p_ext_int_src;
        (~ext_int_n & $past(port1_pin_in[7:4])) == 4'h0;
    endproperty
    a_ext_int_src: assert property (p_ext_int_src) else $error("interrupt not from pin");
    property p_trig_src;
        timer_v_trigger_in |-> $past(port1_pin_in[7]) && ext_int_n[3] && !port1_pin_oe[7];
    endproperty
    a_trig_src: assert property (p_trig_src) else $error("trigger not from pin 7");
    property p_alt_in_undriven;
        (~ext_int_n & port1_pin_oe[7:4]) == 4'h0;
    endproperty
    a_alt_in_undriven: assert property (p_alt_in_undriven) else $error("alt input driven");
endmodule
bind p1g_port p1g_port_properties chk_props (.mclk, .reset_n, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .port1_pin_in, .port1_pin_out, .port1_pin_oe,
    .port1_pullup_on, .ext_int_n, .timer_v_trigger_in);

/* testbench/p1g_pin_model.sv */
// far side of the port pins: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module p1g_pin_model #(
    parameter int W = 9
) (
    input wire logic mclk,
    input wire logic [W-1:0] dev_oe,
    input wire logic [W-1:0] dev_out,
    input wire logic [W-1:0] pull_en,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] level
);
    logic [W-1:0] last = '0;
    // a floating line flips each cycle so a stale level never passes
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (dev_oe[i]) begin
                level[i] = dev_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else if (pull_en[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = ~last[i];
            end
        end
    end
    always_ff @(posedge mclk) begin
        last <= level;
    end
endmodule

/* testbench/p1g_port_test.sv */
// self-checking bench for the port 1 pin function block
`timescale 1ns/1ps
module p1g_port_test import p1g_pkg::*;;
    logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = '0, ext_int_n;
    logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup_on;
    logic port_two_pin_two_in, port_two_pin_two_out, port_two_pin_two_oe, timer_v_trigger_in;
    logic serial_txd = 0, timer_clock = 0;
    logic [8:0] ext_val = 9'h0a5;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int err_total = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    p1g_port u_p1g_port (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .port1_pin_in, .port1_pin_out,
        .port1_pin_oe, .port1_pullup_on, .port_two_pin_two_in, .port_two_pin_two_out,
        .port_two_pin_two_oe, .serial_txd, .timer_clock, .ext_int_n, .timer_v_trigger_in);
    p1g_pin_model #(.W(9)) far_pins (.mclk, .dev_oe({port_two_pin_two_oe, port1_pin_oe}),
        .dev_out({port_two_pin_two_out, port1_pin_out}), .pull_en({1'b0, port1_pullup_on}),
        .ext_en(9'h1ff), .ext_val, .level({port_two_pin_two_in, port1_pin_in}));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic [8:0] e, input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // read results are matched against the oldest note as they appear
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk_bus(nm_q.pop_front(), exp_q.pop_front(), avs_readdata);
        end
    end
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
        int n;
        @(posedge mclk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'($urandom), d};
        avs_byteenable <= b;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            end_of_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task automatic rd(input string n, input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        nm_q.push_back(n);
        bus(1'b0, a, 8'h00, 4'hf);
    endtask
    // pin outputs are registered one edge behind the register
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    initial begin
        logic [7:0] d, o, p, v;
        v = 8'($urandom(16));
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        settle();
        chk_pin("oe", 9'h000, {port_two_pin_two_oe, port1_pin_oe});
        chk_pin("pullup", 9'h000, {1'b0, port1_pullup_on});
        chk_pin("irq", 9'h00f, {4'h0, timer_v_trigger_in, ext_int_n});
        rd("fsel", P1G_OFS_FUNC_SEL, 32'h0000_000c);
        rd("dir", P1G_OFS_DIR, 32'h0000_0000);
        rd("outval", P1G_OFS_OUT_VAL, {24'h0, ext_val[7:0] | 8'h08});
        rd("pullup rd", P1G_OFS_PULLUP, 32'h0000_0008);
        rd("port2", P1G_OFS_PORT2, {30'h0, ext_val[8], 1'b0});
        rd("unmapped", 5'h18, 32'h0000_0000);
        $display("reset state test done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(P1G_OFS_FUNC_SEL, v);
            rd("fsel rd", P1G_OFS_FUNC_SEL, {24'h0, (v & 8'hf3) | 8'h0c});
        end
        wr(P1G_OFS_FUNC_SEL, 8'h00);
        $display("function select test done");
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom) | 8'h08;
            o = 8'($urandom);
            p = 8'($urandom);
            ext_val <= 9'($urandom);
            wr(P1G_OFS_DIR, d);
            d = d & 8'hf7;
            wr(P1G_OFS_OUT_VAL, o);
            wr(P1G_OFS_PULLUP, p);
            settle();
            chk_pin("gpio oe", {1'b0, d}, {port_two_pin_two_oe, port1_pin_oe});
            chk_pin("gpio out", {1'b0, o & d}, {port_two_pin_two_out, port1_pin_out});
            chk_pin("pull on", {1'b0, p & ~d & 8'hf7}, {1'b0, port1_pullup_on});
            rd("outval mix", P1G_OFS_OUT_VAL, {24'h0, (o & d) | (ext_val[7:0] & ~d) | 8'h08});
            rd("pull rd", P1G_OFS_PULLUP, {24'h0, p | 8'h08});
            rd("dir wo", P1G_OFS_DIR, 32'h0000_0000);
        end
        $display("direction test done");
        wr(P1G_OFS_DIR, 8'hff);
        wr(P1G_OFS_OUT_VAL, 8'h00);
        wr(P1G_OFS_FUNC_SEL, 8'hf3);
        for (int i = 0; i < 4; i++) begin
            ext_val <= 9'($urandom);
            serial_txd <= 1'($urandom);
            timer_clock <= 1'($urandom);
            settle();
            chk_pin("alt oe", 9'h107, {port_two_pin_two_oe, port1_pin_oe});
            chk_pin("alt out", {serial_txd, 7'h0, timer_clock},
                {port_two_pin_two_out, port1_pin_out});
            chk_pin("irq", {4'h0, ext_val[7], ext_val[7:4]},
                {4'h0, timer_v_trigger_in, ext_int_n});
            rd("pin lvl", P1G_OFS_PIN_LEVEL, {24'h0, ext_val[7:4], 3'b100, timer_clock});
        end
        wr(P1G_OFS_FUNC_SEL, 8'h00);
        settle();
        chk_pin("gpio back", 9'h0f7, {port_two_pin_two_oe, port1_pin_oe});
        chk_pin("irq off", 9'h00f, {4'h0, timer_v_trigger_in, ext_int_n});
        $display("alternate function test done");
        bus(1'b1, P1G_OFS_FUNC_SEL, 8'hff, 4'he);
        wr(5'h18, 8'hff);
        rd("fsel kept", P1G_OFS_FUNC_SEL, 32'h0000_000c);
        wr(P1G_OFS_PORT2, 8'h03);
        settle();
        chk_pin("p2 drive", 9'h003, {7'h0, port_two_pin_two_oe, port_two_pin_two_out});
        rd("p2 rd", P1G_OFS_PORT2, 32'h0000_0002);
        $display("refusal test done");
        wr(P1G_OFS_FUNC_SEL, 8'hf3);
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        settle();
        chk_pin("oe rst", 9'h000, {port_two_pin_two_oe, port1_pin_oe});
        rd("fsel rst", P1G_OFS_FUNC_SEL, 32'h0000_000c);
        $display("second reset test done");
        end_of_test();
    end
endmodule
